// ---- design/ulm_pkg.sv ----
// constants for the serial port line and modem status block
package ulm_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [2:0] CTL_IDX   = 3'h4;
  localparam logic [2:0] LSTAT_IDX = 3'h5;
  localparam logic [2:0] MSTAT_IDX = 3'h6;
  localparam logic [2:0] SPARE_IDX = 3'h7;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_TERM    = 0;
  localparam int CTL_SEND    = 1;
  localparam int CTL_AUXA    = 2;
  localparam int CTL_AUXB    = 3;
  localparam int CTL_LOOP    = 4;
  localparam int CTL_USED    = 5;
  localparam int TAG_PAR     = 0;
  localparam int TAG_FRM     = 1;
  localparam int TAG_BRK     = 2;
  localparam int MSTAT_CLEAR = 0;
  localparam int MSTAT_SETRD = 1;
  localparam int MSTAT_RING  = 2;
  localparam int MSTAT_CARR  = 3;

  // ****************************************************************
  // reset values and timing counts
  // ****************************************************************
  localparam logic [7:0] CTL_RST         = 8'h00;
  localparam logic [7:0] SPARE_RST       = 8'h00;
  localparam logic [3:0] MSTAT_STATE_RST = 4'h0;
  localparam logic [3:0] HALF_BIT_TICKS = 4'h8;

endpackage : ulm_pkg

// ---- design/ulm_status.sv ----
// line status, modem status, modem control and spare byte registers
`timescale 1ns/1ps
`default_nettype none
module ulm_status
  import ulm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DEPTH  = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              fifo_mode,
  input  wire logic              ier_line_en,
  input  wire logic              ier_tx_en,
  input  wire logic              ier_modem_en,
  input  wire logic              tx_shift_out,
  input  wire logic              tx_hold_write,
  input  wire logic              tx_hold_to_shift,
  input  wire logic              tx_shift_busy,
  input  wire logic              tx_fifo_empty,
  input  wire logic              rx_char_done,
  input  wire logic              rx_char_parity_bad,
  input  wire logic              rx_char_frame_bad,
  input  wire logic              rx_char_break,
  input  wire logic              rx_buf_read,
  input  wire logic              baud_tick16,
  input  wire logic              serial_in,
  input  wire logic              clear_in_n,
  input  wire logic              set_ready_in_n,
  input  wire logic              ring_in_n,
  input  wire logic              carrier_in_n,
  output logic                   serial_out,
  output logic                   rx_line,
  output logic                   rx_restart_ok,
  output logic                   term_ready_out_n,
  output logic                   send_req_out_n,
  output logic                   irq_pin_out,
  output logic                   irq_pin_oe,
  output logic                   line_stat_irq,
  output logic                   tx_empty_irq,
  output logic                   modem_stat_irq
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [7:0]             ctl;
    logic [7:0]             spare;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   mode;
    logic [DEPTH-1:0][2:0]  tags;
    logic [AW-1:0]          rd_ptr;
    logic [AW-1:0]          wr_ptr;
    logic [AW:0]            count;
    logic [AW:0]            err_cnt;
    logic                   oe;
    logic                   par_err;
    logic                   frm_err;
    logic                   brk;
    logic                   hold_empty;
    logic [3:0]             mstate;
    logic [3:0]             mdelta;
    logic                   ser_out;
    logic                   rx_line;
    logic                   rx_ok;
    logic [3:0]             idle_cnt;
    logic                   term_n;
    logic                   send_n;
    logic                   irq;
    logic                   irq_oe;
    logic                   ls_irq;
    logic                   tx_irq;
    logic                   ms_irq;
  } ulm_state_t;

  ulm_state_t r_ff;
  ulm_state_t nxt_r;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // serial in shares the filter so all pins see the same latency
  // the filter costs four cycles but rejects single-cycle glitches
  logic [4:0] pins_sync;

  ulm_sync3 #(
    .W       (5),
    .RST_VAL (5'h1F)
  ) u_pins (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({serial_in, carrier_in_n, ring_in_n, set_ready_in_n, clear_in_n}),
    .sync_out (pins_sync)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:5] == '0) && a[4];
  endfunction : reg_hit

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  logic              loop;
  logic [2:0]        idx;
  logic              setup;
  logic              rd_done;
  logic              wr_done;
  logic              stat_rd;
  logic              mod_rd;
  logic [AW:0]       cap;
  logic              full;
  logic              pop;
  logic              push;
  logic              overrun_ev;
  logic [2:0]        in_tag;
  logic [2:0]        head_tag;
  logic              head_ev;
  logic [3:0]        msrc;
  logic [7:0]        stat_val;
  logic [7:0]        mod_val;
  logic [7:0]        rd_val;

  assign loop    = r_ff.ctl[CTL_LOOP];
  assign idx     = paddr[4:2];
  assign setup   = psel & ~penable;
  assign rd_done = psel & penable & r_ff.pready & ~pwrite;
  assign wr_done = psel & penable & r_ff.pready & pwrite;
  // side effects only on a completed read, not on a write
  assign stat_rd = rd_done & reg_hit(paddr) & (idx == LSTAT_IDX);
  assign mod_rd  = rd_done & reg_hit(paddr) & (idx == MSTAT_IDX);

  // non-fifo mode behaves as a one-entry queue
  assign cap        = fifo_mode ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign full       = (r_ff.count >= cap);
  assign pop        = rx_buf_read & (r_ff.count != '0);
  assign push       = rx_char_done & (~full | pop);
  assign overrun_ev = rx_char_done & full & ~pop;
  assign in_tag     = {rx_char_break, rx_char_frame_bad, rx_char_parity_bad};

  // ****************************************************************
  // head of queue presentation
  // ****************************************************************
  always_comb begin
    head_tag = 3'h0;
    head_ev  = 1'b0;
    if (push && (r_ff.count == '0)) begin
      head_tag = in_tag;
      head_ev  = 1'b1;
    end else if (pop && push && (r_ff.count == (AW+1)'(1))) begin
      // the arriving character replaces the one just read at the head
      head_tag = in_tag;
      head_ev  = 1'b1;
    end else if (pop && (r_ff.count > (AW+1)'(1))) begin
      head_tag = r_ff.tags[ptr_inc(r_ff.rd_ptr)];
      head_ev  = 1'b1;
    end
  end

  // loopback feeds control bits back as modem inputs
  assign msrc = loop ? {r_ff.ctl[CTL_AUXB], r_ff.ctl[CTL_AUXA],
                        r_ff.ctl[CTL_TERM], r_ff.ctl[CTL_SEND]}
                     : ~pins_sync[3:0];

  // idle flag is live so a shifter finishing shows without a strobe
  assign stat_val = {fifo_mode & (r_ff.err_cnt != '0),
                     r_ff.hold_empty & ~tx_shift_busy,
                     r_ff.hold_empty, r_ff.brk, r_ff.frm_err, r_ff.par_err, r_ff.oe,
                     (r_ff.count != '0)};
  assign mod_val  = {r_ff.mstate, r_ff.mdelta};

  always_comb begin
    unique case (idx)
      CTL_IDX:   rd_val = r_ff.ctl;
      LSTAT_IDX: rd_val = stat_val;
      MSTAT_IDX: rd_val = mod_val;
      SPARE_IDX: rd_val = r_ff.spare;
      default: rd_val = 8'h00;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_r = r_ff;

    // bus: data prepared in setup, answered in the first access cycle
    nxt_r.pready  = setup;
    nxt_r.pslverr = setup & ~reg_hit(paddr);
    nxt_r.prdata  = (setup && !pwrite && reg_hit(paddr)) ? {24'h0, rd_val} : 32'h0;

    if (wr_done && reg_hit(paddr)) begin
      if (idx == CTL_IDX) begin
        nxt_r.ctl = {3'h0, pwdata[CTL_USED-1:0]};
      end
      if (idx == SPARE_IDX) begin
        nxt_r.spare = pwdata[7:0];
      end
    end

    // receive queue of error tags, flushed on a mode change
    nxt_r.mode = fifo_mode;
    if (fifo_mode != r_ff.mode) begin
      nxt_r.rd_ptr  = '0;
      nxt_r.wr_ptr  = '0;
      nxt_r.count   = '0;
      nxt_r.err_cnt = '0;
    end else begin
      if (push) begin
        nxt_r.tags[r_ff.wr_ptr] = in_tag;
        nxt_r.wr_ptr            = ptr_inc(r_ff.wr_ptr);
      end
      if (pop) begin
        nxt_r.rd_ptr = ptr_inc(r_ff.rd_ptr);
      end
      nxt_r.count   = (AW+1)'(r_ff.count + push - pop);
      nxt_r.err_cnt = (AW+1)'(r_ff.err_cnt + (push & (|in_tag))
                      - (pop & (|r_ff.tags[r_ff.rd_ptr])));
    end

    // error flags: clear on status read, a new event wins
    // a character landing in the read cycle must not be lost by the clear
    if (stat_rd) begin
      nxt_r.oe      = 1'b0;
      nxt_r.par_err = 1'b0;
      nxt_r.frm_err = 1'b0;
      nxt_r.brk     = 1'b0;
    end
    if (overrun_ev) begin
      nxt_r.oe = 1'b1;
    end
    if (head_ev) begin
      nxt_r.par_err = nxt_r.par_err | head_tag[TAG_PAR];
      nxt_r.frm_err = nxt_r.frm_err | head_tag[TAG_FRM];
      nxt_r.brk     = nxt_r.brk | head_tag[TAG_BRK];
    end

    // new data in the holding register outranks the transfer
    if (fifo_mode) begin
      nxt_r.hold_empty = tx_fifo_empty;
    end else if (tx_hold_write) begin
      nxt_r.hold_empty = 1'b0;
    end else if (tx_hold_to_shift) begin
      nxt_r.hold_empty = 1'b1;
    end

    // modem state and deltas; ring counts only its trailing edge
    nxt_r.mstate = msrc;
    if (mod_rd) begin
      nxt_r.mdelta = 4'h0;
    end
    nxt_r.mdelta = nxt_r.mdelta | {
      msrc[MSTAT_CARR] ^ r_ff.mstate[MSTAT_CARR],
      r_ff.mstate[MSTAT_RING] & ~msrc[MSTAT_RING],
      msrc[MSTAT_SETRD] ^ r_ff.mstate[MSTAT_SETRD],
      msrc[MSTAT_CLEAR] ^ r_ff.mstate[MSTAT_CLEAR]};

    // serial path
    nxt_r.ser_out = loop | tx_shift_out;
    nxt_r.rx_line = loop ? tx_shift_out : pins_sync[4];
    nxt_r.term_n  = loop | ~r_ff.ctl[CTL_TERM];
    nxt_r.send_n  = loop | ~r_ff.ctl[CTL_SEND];

    // no hold after a framing error, so a low line may start a character
    // only a break blocks the restart; the receiver owns the resync
    if (rx_char_break) begin
      nxt_r.rx_ok    = 1'b0;
      nxt_r.idle_cnt = 4'h0;
    end else if (!r_ff.rx_ok) begin
      if (!r_ff.rx_line) begin
        nxt_r.idle_cnt = 4'h0;
      end else if (baud_tick16) begin
        if (r_ff.idle_cnt == HALF_BIT_TICKS - 4'h1) begin
          nxt_r.rx_ok    = 1'b1;
          nxt_r.idle_cnt = 4'h0;
        end else begin
          nxt_r.idle_cnt = r_ff.idle_cnt + 4'h1;
        end
      end
    end

    // interrupt requests follow the updated flags
    nxt_r.ls_irq = ier_line_en & (nxt_r.oe | nxt_r.par_err | nxt_r.frm_err | nxt_r.brk);
    nxt_r.tx_irq = ier_tx_en & nxt_r.hold_empty;
    nxt_r.ms_irq = ier_modem_en & (|nxt_r.mdelta);
    nxt_r.irq    = nxt_r.ls_irq | nxt_r.tx_irq | nxt_r.ms_irq;
    nxt_r.irq_oe = nxt_r.ctl[CTL_AUXB];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff            <= '0;
      r_ff.ctl        <= CTL_RST;
      r_ff.spare      <= SPARE_RST;
      r_ff.mstate     <= MSTAT_STATE_RST;
      r_ff.hold_empty <= 1'b1;
      r_ff.rx_ok      <= 1'b1;
      r_ff.ser_out    <= 1'b1;
      r_ff.rx_line    <= 1'b1;
      r_ff.term_n     <= 1'b1;
      r_ff.send_n     <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata           = r_ff.prdata;
  assign pready           = r_ff.pready;
  assign pslverr          = r_ff.pslverr;
  assign serial_out       = r_ff.ser_out;
  assign rx_line          = r_ff.rx_line;
  assign rx_restart_ok    = r_ff.rx_ok;
  assign term_ready_out_n = r_ff.term_n;
  assign send_req_out_n   = r_ff.send_n;
  assign irq_pin_out      = r_ff.irq;
  assign irq_pin_oe       = r_ff.irq_oe;
  assign line_stat_irq    = r_ff.ls_irq;
  assign tx_empty_irq     = r_ff.tx_irq;
  assign modem_stat_irq   = r_ff.ms_irq;

endmodule : ulm_status
`default_nettype wire

// ---- design/ulm_sync3.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ulm_sync3 #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } ulm_sync_t;

  ulm_sync_t r_ff;
  ulm_sync_t nxt_r;

  always_comb begin
    nxt_r    = r_ff;
    nxt_r.s1 = async_in;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    // a bit only changes once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (r_ff.s2[i] == r_ff.s3[i]) begin
        nxt_r.stable[i] = r_ff.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign sync_out = r_ff.stable;

endmodule : ulm_sync3
`default_nettype wire

// ---- dv/tb_top.sv ----
// register-level bench for the line and modem status block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ulm_pkg::*;
;
  localparam logic [7:0] A_CTL = {3'h0, CTL_IDX, 2'b00};
  localparam logic [7:0] A_LST = {3'h0, LSTAT_IDX, 2'b00};
  localparam logic [7:0] A_MST = {3'h0, MSTAT_IDX, 2'b00};
  localparam logic [7:0] A_SPR = {3'h0, SPARE_IDX, 2'b00};
  localparam logic [7:0] P_HW = 8'h80, P_HS = 8'h40, P_RX = 8'h20, P_PA = 8'h10;
  localparam logic [7:0] P_FR = 8'h08, P_BK = 8'h04, P_RD = 8'h02, P_TK = 8'h01;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, fifo_mode, tx_shift_out, tx_shift_busy, e;
  logic        ier_line_en, ier_tx_en, ier_modem_en, tx_fifo_empty, ring_cmd, carr_cmd;
  logic [7:0]  paddr, pv;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, serial_out, rx_line, rx_restart_ok, term_ready_out_n;
  logic        send_req_out_n, irq_pin_out, irq_pin_oe, line_stat_irq, tx_empty_irq;
  logic        modem_stat_irq, serial_in, clear_in_n, set_ready_in_n, ring_in_n, carrier_in_n;
  wire logic   tx_hold_write, tx_hold_to_shift, rx_char_done, rx_char_parity_bad;
  wire logic   rx_char_frame_bad, rx_char_break, rx_buf_read, baud_tick16;
  int          failures = 0, check_count = 0, cyc = 0;

  assign {tx_hold_write, tx_hold_to_shift, rx_char_done, rx_char_parity_bad,
          rx_char_frame_bad, rx_char_break, rx_buf_read, baud_tick16} = pv;
  always #50 pclk = ~pclk;

  ulm_status ulm_status_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fifo_mode, .ier_line_en, .ier_tx_en, .ier_modem_en,
    .tx_shift_out, .tx_hold_write, .tx_hold_to_shift, .tx_shift_busy, .tx_fifo_empty,
    .rx_char_done, .rx_char_parity_bad, .rx_char_frame_bad, .rx_char_break, .rx_buf_read,
    .baud_tick16, .serial_in, .clear_in_n, .set_ready_in_n, .ring_in_n, .carrier_in_n,
    .serial_out, .rx_line, .rx_restart_ok, .term_ready_out_n, .send_req_out_n,
    .irq_pin_out, .irq_pin_oe, .line_stat_irq, .tx_empty_irq, .modem_stat_irq);
  ulm_modem_peer ulm_modem_peer_i (.pclk, .term_ready_out_n, .send_req_out_n, .serial_out,
    .ring_cmd, .carr_cmd, .clear_in_n, .set_ready_in_n, .ring_in_n, .carrier_in_n,
    .serial_in);

  // ******************************************
  // tasks
  // ******************************************
  task automatic print_verdict();
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) failures++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rdc
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  // a gap cycle after each pulse keeps back-to-back events distinct
  task automatic pulse(input logic [7:0] v);
    pv <= v;
    @(posedge pclk);
    pv <= 8'h00;
    @(posedge pclk);
  endtask : pulse

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      print_verdict();
    end
  end

  // ******************************************
  // main sequence
  // ******************************************
  initial begin
    {psel, penable, pwrite, presetn, fifo_mode, tx_shift_busy, ring_cmd, carr_cmd} = 8'h00;
    {ier_line_en, ier_tx_en, ier_modem_en, tx_fifo_empty, tx_shift_out} = 5'h1F;
    paddr = 8'h00;
    pwdata = 32'h0;
    pv = 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    idle(2);
    chk({irq_pin_oe, tx_empty_irq}, 2'b01);
    rdc(A_CTL, 32'h0);
    apb(1'b1, A_SPR, 32'h0000_00A5);
    rdc(A_SPR, 32'hA5);
    apb(1'b0, 8'h20, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    apb(1'b1, A_CTL, 32'h0000_00FF);
    rdc(A_CTL, 32'h1F);
    chk({serial_out, term_ready_out_n, send_req_out_n, irq_pin_oe}, 4'hF);
    tx_shift_out <= 1'b0;
    idle(3);
    chk({serial_out, rx_line}, 2'b10);
    tx_shift_out <= 1'b1;
    chk(modem_stat_irq, 1'b1);
    rdc(A_MST, 32'hFB);
    rdc(A_MST, 32'hF0);
    apb(1'b1, A_CTL, 32'h0000_0013);
    idle(2);
    rdc(A_MST, 32'h3C);
    apb(1'b1, A_CTL, 32'h0000_0003);
    idle(12);
    chk({term_ready_out_n, send_req_out_n, irq_pin_oe, modem_stat_irq}, 4'h1);
    rdc(A_MST, 32'h33);
    ring_cmd <= 1'b1;
    idle(12);
    ring_cmd <= 1'b0;
    idle(12);
    apb(1'b1, A_MST, 32'h0000_00FF);
    rdc(A_MST, 32'h34);
    rdc(A_MST, 32'h30);
    idle(1);
    chk(modem_stat_irq, 1'b0);
    ier_modem_en <= 1'b0;
    carr_cmd <= 1'b1;
    idle(12);
    chk(modem_stat_irq, 1'b0);
    ier_modem_en <= 1'b1;
    idle(2);
    chk(modem_stat_irq, 1'b1);
    rdc(A_MST, 32'hB8);
    rdc(A_LST, 32'h60);
    pulse(P_HW);
    rdc(A_LST, 32'h00);
    chk(tx_empty_irq, 1'b0);
    chk(irq_pin_out, 1'b0);
    tx_shift_busy <= 1'b1;
    pulse(P_HS);
    rdc(A_LST, 32'h20);
    tx_shift_busy <= 1'b0;
    idle(2);
    rdc(A_LST, 32'h60);
    pulse(P_RX | P_PA);
    idle(1);
    chk(line_stat_irq, 1'b1);
    chk(irq_pin_out, 1'b1);
    rdc(A_LST, 32'h65);
    rdc(A_LST, 32'h61);
    pulse(P_RX);
    rdc(A_LST, 32'h63);
    pulse(P_RD);
    rdc(A_LST, 32'h60);
    pulse(P_RX | P_FR);
    rdc(A_LST, 32'h69);
    pulse(P_RD);
    rdc(A_LST, 32'h60);
    fifo_mode <= 1'b1;
    idle(2);
    pulse(P_RX);
    pulse(P_RX | P_BK);
    idle(1);
    chk(rx_restart_ok, 1'b0);
    rdc(A_LST, 32'hE1);
    pulse(P_RD);
    rdc(A_LST, 32'hF1);
    rdc(A_LST, 32'hE1);
    pulse(P_RD);
    rdc(A_LST, 32'h60);
    repeat (6) pulse(P_TK);
    chk(rx_restart_ok, 1'b0);
    repeat (6) pulse(P_TK);
    chk(rx_restart_ok, 1'b1);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// ---- dv/ulm_modem_peer.sv ----
// modem peer model on the serial port pins
`timescale 1ns/1ps
`default_nettype none
module ulm_modem_peer (
  input  wire logic pclk,
  input  wire logic term_ready_out_n,
  input  wire logic send_req_out_n,
  input  wire logic serial_out,
  input  wire logic ring_cmd,
  input  wire logic carr_cmd,
  output var logic  clear_in_n,
  output var logic  set_ready_in_n,
  output var logic  ring_in_n,
  output var logic  carrier_in_n,
  output var logic  serial_in
);
  // ******************************************
  // null-modem echo of the handshake lines; ring and carrier follow the bench commands
  // ******************************************
  initial begin
    {clear_in_n, set_ready_in_n, ring_in_n, carrier_in_n, serial_in} = 5'h1F;
  end
  always @(posedge pclk) begin
    clear_in_n     <= send_req_out_n;
    set_ready_in_n <= term_ready_out_n;
    ring_in_n      <= !ring_cmd;
    carrier_in_n   <= !carr_cmd;
    // line echoes serial_out, so it sits at mark between frames only when the transmitter does
    serial_in      <= serial_out;
  end
endmodule : ulm_modem_peer
`default_nettype wire

// ---- dv/ulm_status_chk.sv ----
// port-level assertions for the line and modem status block
`timescale 1ns/1ps
`default_nettype none
module ulm_status_chk
  import ulm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              fifo_mode,
  input wire logic              ier_line_en,
  input wire logic              ier_modem_en,
  input wire logic              rx_char_done,
  input wire logic              rx_char_parity_bad,
  input wire logic              serial_out,
  input wire logic              term_ready_out_n,
  input wire logic              send_req_out_n,
  input wire logic              irq_pin_oe,
  input wire logic              line_stat_irq,
  input wire logic              modem_stat_irq
);
  // ******************************************
  // helpers and properties
  // ******************************************
  localparam logic [ADDR_W-1:0] A_CTL = ADDR_W'({CTL_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_LST = ADDR_W'({LSTAT_IDX, 2'b00});
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup  = psel && !penable;
  wire logic unmap  = !(paddr[ADDR_W-1:5] == '0 && paddr[4] && paddr[1:0] == 2'b00);
  wire logic done   = psel && penable && pready;
  wire logic ctl_wr = done && pwrite && paddr == A_CTL;
  wire logic rd_ctl = done && !pwrite && paddr == A_CTL;
  wire logic rd_lst = done && !pwrite && paddr == A_LST;

  a_pready_once: assert property (setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_slverr_map: assert property (setup |=> pslverr == $past(unmap))
    else $error("pslverr does not match address map");
  a_auxb_gate: assert property (ctl_wr |-> ##2 irq_pin_oe == $past(pwdata[CTL_AUXB], 2))
    else $error("interrupt enable pin not following control bit 3");
  a_loop_mark: assert property (ctl_wr && pwdata[CTL_LOOP] |-> ##2
    serial_out && term_ready_out_n && send_req_out_n)
    else $error("loopback does not hold outputs high");
  a_ctrl_drive: assert property (ctl_wr && !pwdata[CTL_LOOP] |-> ##2
    term_ready_out_n == !$past(pwdata[CTL_TERM], 2) && send_req_out_n == !$past(pwdata[CTL_SEND], 2))
    else $error("control outputs not the inverse of control bits");
  a_ctl_top: assert property (rd_ctl |-> prdata[7:5] == 3'h0)
    else $error("upper control bits read nonzero");
  a_lst_top: assert property (rd_lst && !fifo_mode && !$past(fifo_mode) |-> !prdata[7])
    else $error("status bit 7 set outside fifo mode");
  a_line_irq: assert property (rx_char_done && rx_char_parity_bad && ier_line_en
    && !fifo_mode |-> ##[1:2] line_stat_irq)
    else $error("parity error raised no line interrupt");
  a_modem_gate: assert property (!ier_modem_en && $past(!ier_modem_en) |-> !modem_stat_irq)
    else $error("modem interrupt while disabled");

  c_loop: cover property (ctl_wr && pwdata[CTL_LOOP]);
  c_modem: cover property ($rose(modem_stat_irq));
  c_err: cover property (done && pslverr);
endmodule : ulm_status_chk
bind ulm_status ulm_status_chk #(.ADDR_W(ADDR_W)) ulm_status_chk_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fifo_mode, .ier_line_en,
  .ier_modem_en, .rx_char_done, .rx_char_parity_bad, .serial_out, .term_ready_out_n,
  .send_req_out_n, .irq_pin_oe, .line_stat_irq, .modem_stat_irq);
`default_nettype wire
